// *** core/emib_consts.svh ***
// Purpose: Constants for the external memory and I/O bus controller
// Assumes: One system clock at 250 MHz; bus clock output derived from it
// Notes:   Offsets do not apply; the block has no software-visible registers
`ifndef EMIB_CONSTS_SVH
`define EMIB_CONSTS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define EMIB_ADDR_W        20
`define EMIB_DATA_W        16
`define EMIB_SW_W          3
`define EMIB_PH_W          2

// ****************************************************************
// Timing
// ****************************************************************
`define EMIB_SYS_CLK_NS    4
`define EMIB_HALF_NS       8
`define EMIB_HALF_CYC      (`EMIB_HALF_NS / `EMIB_SYS_CLK_NS)
`define EMIB_FALL_PH       2'h1
`define EMIB_RISE_PH       2'h3
`define EMIB_MIN_SW_READY  3'h2

// ****************************************************************
// Reset values and the forced upper address value
// ****************************************************************
`define EMIB_ADDR_RST      20'h0_0000
`define EMIB_DATA_RST      16'h0000
`define EMIB_SW_RST        3'h0
`define EMIB_PH_RST        2'h0
`define EMIB_UPPER_ZERO    4'h0

`endif

// *** core/emib_pkg.sv ***
// Purpose: Types shared by the external bus controller files
// Assumes: Constants come from emib_consts.svh
// Notes:   No numbers live here, only type shapes
package emib_pkg;

  typedef enum logic [1:0] {
    EMIB_SPACE_PROG,
    EMIB_SPACE_DATA,
    EMIB_SPACE_IO
  } emib_space_e;

  typedef enum logic [2:0] {
    EMIB_ST_IDLE,
    EMIB_ST_ADDR,
    EMIB_ST_STRB,
    EMIB_ST_RECOV
  } emib_state_e;

endpackage : emib_pkg

// *** core/emib_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   Stage one is read only by stage two
`timescale 1ns/100ps
`default_nettype none
module emib_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : emib_sync
`default_nettype wire

// *** core/emib_phase_gen.sv ***
// Purpose: Divides sys_clk into the bus clock output and its edge ticks
// Assumes: Half period of the bus clock is EMIB_HALF_CYC sys_clk cycles
// Notes:   Ticks lead the matching bus clock edge by one sys_clk cycle
`timescale 1ns/100ps
`default_nettype none
`include "emib_consts.svh"
module emib_phase_gen (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      clock_output,
  output logic      fall_tick,
  output logic      rise_tick
);

  logic [`EMIB_PH_W-1:0] ph_reg;
  logic [`EMIB_PH_W-1:0] ph_next;
  logic                  clk_reg;

  assign ph_next = ph_reg + 2'h1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_reg  <= `EMIB_PH_RST;
      clk_reg <= 1'b1;
    end else begin
      ph_reg  <= ph_next;
      clk_reg <= ~ph_next[1];
    end
  end

  // Registered outputs change at the edge that follows the tick
  assign fall_tick    = (ph_reg == `EMIB_FALL_PH);
  assign rise_tick    = (ph_reg == `EMIB_RISE_PH);
  assign clock_output = clk_reg;

endmodule : emib_phase_gen
`default_nettype wire

// *** core/emib_bus_ctrl.sv ***
// Purpose: External memory and I/O parallel bus cycle sequencer
// Assumes: One request at a time; request side runs on sys_clk
// Notes:   Bus clock output is sys_clk divided by four
// Contract
// - Memory reads run consecutive or nonconsecutive as the consecutive-read bit selects.
// - Upper address bits 19:16 are driven low for every data-space access.
// - Upper address bits 19:16 are driven low for every I/O-space access.
// - Ready can stretch a cycle only when at least two software wait states are set.
// - Ready is not looked at until the software wait states are used up.
// - Ready is sampled at a falling edge of the bus clock output.
// - The memory strobe changes only at falling edges of the bus clock output.
// - The I/O strobe changes only at rising edges of the bus clock output.
// - A memory write pulls the read/write line low half a period before the strobe.
// - Data is driven only while read/write is low and released by the time it rises.
// - Memory read data is captured at the falling edge that ends the cycle.
// - I/O read data is captured at the rising edge that ends the cycle.
// - Space selects switch together with the address.
// - State-complete goes low before a falling edge and high right after one.
`timescale 1ns/100ps
`default_nettype none
`include "emib_consts.svh"
module emib_bus_ctrl (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire logic                      req_write,
  input  wire emib_pkg::emib_space_e     req_space,
  input  wire logic [`EMIB_ADDR_W-1:0]   req_addr,
  input  wire logic [`EMIB_DATA_W-1:0]   req_wdata,
  input  wire logic [`EMIB_SW_W-1:0]     req_sw_wait,
  input  wire logic                      consecutive_read_select,
  output logic                           rsp_valid,
  output logic [`EMIB_DATA_W-1:0]        rsp_rdata,
  output logic                           clock_output,
  output logic [`EMIB_ADDR_W-1:0]        addr_out,
  output logic                           program_space_select_n,
  output logic                           data_space_select_n,
  output logic                           io_space_select_n,
  output logic                           memory_strobe_n,
  output logic                           io_strobe_n,
  output logic                           read_write,
  output logic [`EMIB_DATA_W-1:0]        data_out,
  output logic                           data_oe,
  input  wire logic [`EMIB_DATA_W-1:0]   data_in,
  input  wire logic                      ready_in,
  output logic                           state_complete_n
);
  import emib_pkg::*;

  // ****************************************************************
  // Clocking and pin synchronisers
  // ****************************************************************
  logic                    fall_tick;
  logic                    rise_tick;
  logic                    ready_s;
  logic [`EMIB_DATA_W-1:0] data_s;

  emib_phase_gen u_phase (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .clock_output (clock_output),
    .fall_tick    (fall_tick),
    .rise_tick    (rise_tick)
  );

  emib_sync #(.W(1)) u_sync_ready (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (ready_in),
    .sync_out (ready_s)
  );

  // Pin data is two sys_clk old when sampled, so it must settle H before the edge
  emib_sync #(.W(`EMIB_DATA_W)) u_sync_data (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (data_in),
    .sync_out (data_s)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  emib_state_e             st_reg;
  emib_space_e             space_reg;
  logic                    write_reg;
  logic [`EMIB_SW_W-1:0]   sw_reg;
  logic [`EMIB_SW_W-1:0]   wcnt_reg;
  logic                    rdy_reg;
  logic [`EMIB_ADDR_W-1:0] addr_reg;
  logic [`EMIB_DATA_W-1:0] wdata_reg;
  logic [`EMIB_DATA_W-1:0] rdata_reg;
  logic                    psel_reg;
  logic                    dsel_reg;
  logic                    isel_reg;
  logic                    memory_strobe_n_reg;
  logic                    io_strobe_n_reg;
  logic                    rw_reg;
  logic                    oe_reg;
  logic                    rsp_valid_reg;
  logic                    msc_reg;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire io_cyc        = (space_reg == EMIB_SPACE_IO);
  wire strobe_evt    = io_cyc ? rise_tick : fall_tick;
  wire sw_allows_rdy = (sw_reg >= `EMIB_MIN_SW_READY);
  wire ext_hold      = sw_allows_rdy && !ready_s;
  wire done_ok       = io_cyc ? rdy_reg : !ext_hold;
  wire waits_left    = (wcnt_reg != `EMIB_SW_RST);
  wire in_strb       = (st_reg == EMIB_ST_STRB);
  wire finish        = in_strb && strobe_evt && !waits_left && done_ok;
  wire next_mem_rd   = req_valid && !req_write && (req_space != EMIB_SPACE_IO);
  wire chain         = finish && !io_cyc && !write_reg
                       && consecutive_read_select && next_mem_rd;
  wire start         = (st_reg == EMIB_ST_IDLE) && fall_tick && req_valid;
  wire upper_zero    = (req_space != EMIB_SPACE_PROG);
  wire [`EMIB_ADDR_W-1:0] addr_next =
    {upper_zero ? `EMIB_UPPER_ZERO : req_addr[19:16], req_addr[15:0]};
  wire recov_evt     = io_cyc ? fall_tick : rise_tick;

  assign req_ready = start || chain;

  // ****************************************************************
  // Request latch: address and selects move on the same edge
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      space_reg <= EMIB_SPACE_PROG;
      write_reg <= 1'b0;
      sw_reg    <= `EMIB_SW_RST;
      addr_reg  <= `EMIB_ADDR_RST;
      wdata_reg <= `EMIB_DATA_RST;
      psel_reg  <= 1'b1;
      dsel_reg  <= 1'b1;
      isel_reg  <= 1'b1;
    end else if (req_ready) begin
      space_reg <= req_space;
      write_reg <= req_write;
      sw_reg    <= req_sw_wait;
      addr_reg  <= addr_next;
      wdata_reg <= req_wdata;
      psel_reg  <= (req_space != EMIB_SPACE_PROG);
      dsel_reg  <= (req_space != EMIB_SPACE_DATA);
      isel_reg  <= (req_space != EMIB_SPACE_IO);
    end
  end

  // ****************************************************************
  // State-complete marker
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msc_reg <= 1'b1;
    end else if (fall_tick) begin
      msc_reg <= 1'b1;
    end else if (rise_tick && in_strb && !waits_left) begin
      msc_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg        <= EMIB_ST_IDLE;
      wcnt_reg      <= `EMIB_SW_RST;
      rdy_reg       <= 1'b0;
      rdata_reg     <= `EMIB_DATA_RST;
      memory_strobe_n_reg     <= 1'b1;
      io_strobe_n_reg    <= 1'b1;
      rw_reg        <= 1'b1;
      oe_reg        <= 1'b0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (st_reg)
        EMIB_ST_IDLE: begin
          if (start) begin
            st_reg <= EMIB_ST_ADDR;
            // I/O writes lower read/write with the address
            if (req_write && req_space == EMIB_SPACE_IO) begin
              rw_reg <= 1'b0;
            end
          end
        end
        EMIB_ST_ADDR: begin
          if (rise_tick && write_reg && !io_cyc) begin
            rw_reg <= 1'b0;
          end
          if (strobe_evt) begin
            memory_strobe_n_reg  <= io_cyc;
            io_strobe_n_reg <= !io_cyc;
            oe_reg     <= write_reg;
            wcnt_reg   <= sw_reg;
            rdy_reg    <= 1'b0;
            st_reg     <= EMIB_ST_STRB;
          end
        end
        EMIB_ST_STRB: begin
          // I/O cycles end on a rise, so ready is caught at the fall before
          if (fall_tick && io_cyc && !waits_left) begin
            rdy_reg <= !ext_hold;
          end
          if (strobe_evt && waits_left) begin
            wcnt_reg <= wcnt_reg - 3'h1;
          end else if (finish) begin
            rsp_valid_reg <= 1'b1;
            if (!write_reg) begin
              rdata_reg <= data_s;
            end
            if (chain) begin
              wcnt_reg <= req_sw_wait;
              rdy_reg  <= 1'b0;
            end else begin
              memory_strobe_n_reg  <= 1'b1;
              io_strobe_n_reg <= 1'b1;
              st_reg     <= write_reg ? EMIB_ST_RECOV : EMIB_ST_IDLE;
            end
          end
        end
        EMIB_ST_RECOV: begin
          if (recov_evt) begin
            rw_reg <= 1'b1;
            oe_reg <= 1'b0;
            st_reg <= EMIB_ST_IDLE;
          end
        end
        default: begin
          st_reg <= EMIB_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_valid              = rsp_valid_reg;
  assign rsp_rdata              = rdata_reg;
  assign addr_out               = addr_reg;
  assign program_space_select_n = psel_reg;
  assign data_space_select_n    = dsel_reg;
  assign io_space_select_n      = isel_reg;
  assign memory_strobe_n        = memory_strobe_n_reg;
  assign io_strobe_n            = io_strobe_n_reg;
  assign read_write             = rw_reg;
  assign data_out               = wdata_reg;
  assign data_oe                = oe_reg;
  assign state_complete_n       = msc_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  upper_data_low_a: assert property (
    !data_space_select_n |-> addr_out[19:16] == 4'h0)
    else $error("upper address not low in data space");

  upper_io_low_a: assert property (
    !io_space_select_n |-> addr_out[19:16] == 4'h0)
    else $error("upper address not low in io space");

  memory_strobe_n_on_fall_a: assert property (
    $changed(memory_strobe_n) |-> $past(fall_tick) && !clock_output)
    else $error("memory strobe moved off a falling edge");

  io_strobe_n_on_rise_a: assert property (
    $changed(io_strobe_n) |-> $past(rise_tick) && clock_output)
    else $error("io strobe moved off a rising edge");

  rw_lead_a: assert property (
    $fell(memory_strobe_n) && !read_write |-> $past(read_write, 2) == 1'b0
      && $past(read_write, 3) == 1'b1)
    else $error("read/write did not lead memory strobe by half a period");

  data_drive_a: assert property (
    data_oe |-> !read_write)
    else $error("data driven while read/write high");

  sw_done_first_a: assert property (
    $rose(rsp_valid) |-> $past(wcnt_reg) == 3'h0)
    else $error("cycle ended before software waits completed");

  ext_wait_hold_a: assert property (
    fall_tick && in_strb && !io_cyc && !waits_left && sw_allows_rdy && !ready_s
      |=> !memory_strobe_n && $stable(addr_out) && !rsp_valid)
    else $error("low ready did not extend the memory cycle");

  short_sw_ignores_a: assert property (
    fall_tick && in_strb && !io_cyc && !waits_left && !sw_allows_rdy
      |=> rsp_valid)
    else $error("ready extended a cycle with under two software waits");

  mem_capture_a: assert property (
    rsp_valid && !write_reg && !io_cyc |-> $past(fall_tick) && rsp_rdata == $past(data_s))
    else $error("memory read data not taken at falling edge");

  io_capture_a: assert property (
    rsp_valid && !write_reg && io_cyc |-> $past(rise_tick) && rsp_rdata == $past(data_s))
    else $error("io read data not taken at rising edge");

  select_with_addr_a: assert property (
    $changed({program_space_select_n, data_space_select_n, io_space_select_n})
      |-> $past(fall_tick))
    else $error("space select switched apart from the address");

  msc_edges_a: assert property (
    $rose(state_complete_n) |-> $past(fall_tick) && !clock_output)
    else $error("state complete released off a falling edge");

  nonconsec_gap_a: assert property (
    rsp_valid && !write_reg && !io_cyc && !$past(consecutive_read_select)
      |-> memory_strobe_n)
    else $error("strobe held low in nonconsecutive mode");

  mem_ext_wait_c: cover property (
    in_strb && !io_cyc && ext_hold && fall_tick && !waits_left);
  consecutive_read_select_chain_c: cover property (chain);
  io_write_c: cover property (rsp_valid && io_cyc && write_reg);
  mem_write_c: cover property (rsp_valid && !io_cyc && write_reg);

endmodule : emib_bus_ctrl
`default_nettype wire

// *** bench/emib_ext_model.sv ***
// Purpose: Behavioural external memory and I/O peripheral on the far side of the bus
// Assumes: Timed only by bus pins: the clock output, the strobes, read/write and the address
// Notes:   Ready is held low for ready_hold falls of the bus clock after a strobe goes low
`timescale 1ns/100ps
`default_nettype none
module emib_ext_model (
  input  wire logic        clock_output,
  input  wire logic [19:0] addr_out,
  input  wire logic        memory_strobe_n,
  input  wire logic        io_strobe_n,
  input  wire logic        read_write,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic [3:0]  ready_hold,
  output logic      [15:0] data_in,
  output logic             ready_in,
  output logic      [19:0] wr_addr,
  output logic      [15:0] wr_data
);
  logic [3:0] fall_cnt;

  initial begin
    data_in  = 16'h0000;
    ready_in = 1'b1;
    fall_cnt = 4'h0;
    wr_addr  = 20'h0_0000;
    wr_data  = 16'h0000;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Outside a read strobe the bus is released; toggle so a stale capture shows
  always @(memory_strobe_n, io_strobe_n, read_write, addr_out) begin
    if (!memory_strobe_n && read_write)
      data_in = addr_out[15:0] ^ 16'h5A5A;
    else if (!io_strobe_n && read_write)
      data_in = addr_out[15:0] ^ 16'hC3C3;
    else
      data_in = ~data_in;
  end

  // ****************************************************************
  // Ready
  // ****************************************************************
  // Moves just after a fall, so it is stable for a whole period around the next one
  always @(negedge clock_output) begin
    #1;
    if (!memory_strobe_n || !io_strobe_n)
      fall_cnt = fall_cnt + 4'h1;
    else
      fall_cnt = 4'h0;
    ready_in = (fall_cnt >= ready_hold);
  end

  // ****************************************************************
  // Write capture
  // ****************************************************************
  always @(posedge memory_strobe_n, posedge io_strobe_n) begin
    if (data_oe && !read_write) begin
      wr_addr = addr_out;
      wr_data = data_out;
    end
  end
endmodule : emib_ext_model
`default_nettype wire

// *** bench/emib_bus_ctrl_test.sv ***
// Purpose: Self-checking bench for the external bus cycle sequencer
// Assumes: Far side is emib_ext_model; sys_clk at 250 MHz
// Notes:   Latency is counted in sys_clk cycles from the edge that takes the request
`timescale 1ns/100ps
`default_nettype none
`include "emib_consts.svh"
module emib_bus_ctrl_test;
  import emib_pkg::*;
  logic                    sys_clk, rst, req_valid, req_ready, req_write, rsp_valid;
  logic                    consecutive_read_select, clock_output, data_oe, ready_in;
  logic                    program_space_select_n, data_space_select_n, io_space_select_n;
  logic                    memory_strobe_n, io_strobe_n, read_write, state_complete_n;
  emib_space_e             req_space;
  logic [`EMIB_ADDR_W-1:0] req_addr, addr_out, wr_addr;
  logic [`EMIB_DATA_W-1:0] req_wdata, rsp_rdata, data_out, data_in, wr_data;
  logic [`EMIB_SW_W-1:0]   req_sw_wait;
  logic [3:0]              ready_hold;
  logic                    ms_p, is_p, sc_p, co_p;
  int                      failures, cmp_count, ms_rise, rw_cnt;
  wire [19:0]              co_pair  = 20'({co_p, clock_output});
  wire [19:0]              sel_bits =
    20'({program_space_select_n, data_space_select_n, io_space_select_n});

  emib_bus_ctrl uut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_space(req_space),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_sw_wait(req_sw_wait),
    .consecutive_read_select(consecutive_read_select), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .clock_output(clock_output), .addr_out(addr_out),
    .program_space_select_n(program_space_select_n),
    .data_space_select_n(data_space_select_n), .io_space_select_n(io_space_select_n),
    .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n),
    .read_write(read_write), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .ready_in(ready_in), .state_complete_n(state_complete_n));

  emib_ext_model far (.clock_output(clock_output), .addr_out(addr_out),
    .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n),
    .read_write(read_write), .data_out(data_out), .data_oe(data_oe),
    .ready_hold(ready_hold), .data_in(data_in), .ready_in(ready_in),
    .wr_addr(wr_addr), .wr_data(wr_data));

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #40000;
    failures++;
    end_of_test;
  end

  // Pin edge monitor; sampled mid-cycle so every update has landed
  always @(negedge sys_clk) begin
    if (!rst) begin
      if (memory_strobe_n !== ms_p) check("mstrobe edge", co_pair, 20'h0_0002);
      if (io_strobe_n !== is_p) check("iostrobe edge", co_pair, 20'h0_0001);
      if (state_complete_n !== sc_p)
        check("complete edge", co_pair, state_complete_n ? 20'h0_0002 : 20'h0_0001);
      if (data_oe) check("drive while write", 20'(read_write), 20'h0_0000);
      if (ms_p && !memory_strobe_n && !read_write) check("rw lead", 20'(rw_cnt), 20'd2);
      if (!ms_p && memory_strobe_n) ms_rise++;
      rw_cnt = read_write ? 0 : rw_cnt + 1;
    end
    {ms_p, is_p, sc_p, co_p} = {memory_strobe_n, io_strobe_n, state_complete_n, clock_output};
  end

  // ****************************************************************
  // Bus request
  // ****************************************************************
  task automatic do_req(input logic wr, input emib_space_e sp, input logic [19:0] a,
                        input logic [15:0] wd, input logic [2:0] sw, input logic [3:0] hold,
                        output logic [15:0] rd, output int lat);
    int n;
    @(posedge sys_clk);
    req_valid   <= 1'b1;
    req_write   <= wr;
    req_space   <= sp;
    req_addr    <= a;
    req_wdata   <= wd;
    req_sw_wait <= sw;
    ready_hold  <= hold;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 50);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 100);
    lat = n;
    rd = rsp_rdata;
  endtask : do_req

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_mem;
    logic [15:0] rd;
    int          lat;
    do_req(1'b0, EMIB_SPACE_PROG, 20'hA_1234, 16'h0000, 3'h0, 4'h0, rd, lat);
    check("prog data", 20'(rd), 20'(16'h1234 ^ 16'h5A5A));
    check("prog lat", 20'(lat), 20'd9);
    check("prog addr", addr_out, 20'hA_1234);
    check("prog sel", sel_bits, 20'h0_0003);
    do_req(1'b1, EMIB_SPACE_DATA, 20'hF_0042, 16'hBEEF, 3'h0, 4'h0, rd, lat);
    check("data wr lat", 20'(lat), 20'd9);
    check("data wr addr", wr_addr, 20'h0_0042);
    check("data wr data", 20'(wr_data), 20'h0_BEEF);
    check("data sel", sel_bits, 20'h0_0005);
    do_req(1'b0, EMIB_SPACE_DATA, 20'h9_0077, 16'h0000, 3'h0, 4'h0, rd, lat);
    check("data rd addr", addr_out, 20'h0_0077);
    check("data rd data", 20'(rd), 20'(16'h0077 ^ 16'h5A5A));
    $display("test memory done");
  endtask : t_mem

  task automatic t_io;
    logic [15:0] rd;
    int          lat;
    do_req(1'b1, EMIB_SPACE_IO, 20'h7_00AB, 16'h1357, 3'h0, 4'h0, rd, lat);
    check("io wr lat", 20'(lat), 20'd7);
    check("io wr addr", wr_addr, 20'h0_00AB);
    check("io wr data", 20'(wr_data), 20'h0_1357);
    check("io sel", sel_bits, 20'h0_0006);
    do_req(1'b0, EMIB_SPACE_IO, 20'h3_0011, 16'h0000, 3'h0, 4'h0, rd, lat);
    check("io rd lat", 20'(lat), 20'd7);
    check("io rd addr", addr_out, 20'h0_0011);
    check("io rd data", 20'(rd), 20'(16'h0011 ^ 16'hC3C3));
    $display("test io done");
  endtask : t_io

  task automatic t_waits;
    logic        io [6]  = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic        wr [6]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [2:0]  sw [6]  = '{3'h2, 3'h3, 3'h2, 3'h1, 3'h2, 3'h2};
    logic [3:0]  hld [6] = '{4'h5, 4'h0, 4'h3, 4'hF, 4'h4, 4'h4};
    int          exp [6] = '{25, 21, 19, 13, 21, 23};
    logic [15:0] rd;
    int          lat;
    for (int i = 0; i < 6; i++) begin
      do_req(wr[i], io[i] ? EMIB_SPACE_IO : EMIB_SPACE_DATA, 20'h0_0100 + 20'(i),
             16'h2460 + 16'(i), sw[i], hld[i], rd, lat);
      check("wait lat", 20'(lat), 20'(exp[i]));
      if (!wr[i]) check("wait rd data", 20'(rd),
                        20'((16'h0100 + 16'(i)) ^ (io[i] ? 16'hC3C3 : 16'h5A5A)));
      if (wr[i]) check("wait wr data", 20'(wr_data), 20'(16'h2460 + 16'(i)));
    end
    $display("test waits done");
  endtask : t_waits

  task automatic t_consecutive_read_select(input logic c);
    int taken;
    int got;
    taken = 0;
    got = 0;
    @(posedge sys_clk);
    consecutive_read_select <= c;
    ready_hold  <= 4'h0;
    ms_rise = 0;
    req_valid   <= 1'b1;
    req_write   <= 1'b0;
    req_space   <= EMIB_SPACE_PROG;
    req_addr    <= 20'h1_0200;
    req_sw_wait <= 3'h0;
    for (int i = 0; i < 80 && got < 2; i++) begin
      @(negedge sys_clk);
      if (rsp_valid === 1'b1) begin
        check("chain data", 20'(rsp_rdata), 20'(16'h0200 + 16'(got)) ^ 20'h0_5A5A);
        got++;
      end
      if (req_ready === 1'b1) begin
        taken++;
        @(posedge sys_clk);
        if (taken == 1) req_addr <= 20'h1_0201;
        else req_valid <= 1'b0;
      end
    end
    // Let the monitor count the last strobe rise before it is read
    @(negedge sys_clk);
    check("chain count", 20'(got), 20'd2);
    check("chain strobe rises", 20'(ms_rise), c ? 20'd1 : 20'd2);
    $display("test consecutive %0d done", c);
  endtask : t_consecutive_read_select

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = EMIB_SPACE_PROG;
    req_addr = 20'h0_0000;
    req_wdata = 16'h0000;
    req_sw_wait = 3'h0;
    consecutive_read_select = 1'b0;
    ready_hold = 4'h0;
    failures = 0;
    cmp_count = 0;
    ms_rise = 0;
    rw_cnt = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_mem;
    t_io;
    t_waits;
    t_consecutive_read_select(1'b1);
    t_consecutive_read_select(1'b0);
    end_of_test;
  end
endmodule : emib_bus_ctrl_test
`default_nettype wire
